// >>> rtl/snt_cfg.svh
`ifndef SNT_CFG_SVH
`define SNT_CFG_SVH

// register offsets, primary space
`define SNT_ADDR_CFG 7'h00
`define SNT_ADDR_TIMEN 7'h01
`define SNT_ADDR_ACKLEN 7'h02
`define SNT_ADDR_STATUS 7'h03
`define SNT_ADDR_ACKPL 7'h04
`define SNT_ADDR_IDTAB 7'h08
`define SNT_ADDR_IDNEW 7'h34
`define SNT_ADDR_DLEN 7'h37
`define SNT_ADDR_DBUF 7'h38
// secondary register space, selected by the bank bit
`define SNT_ADDR_TIMTAB 7'h0C

// configuration register fields
`define SNT_CFG_BANK 0
`define SNT_CFG_PWR 1
`define SNT_CFG_STREAM 3
`define SNT_CFG_UNIDIR 4
`define SNT_CFG_TIMDIS 5
`define SNT_CFG_MASEN 7
`define SNT_CFG_RST 8'h00
`define SNT_TIMEN_RST 8'h00
`define SNT_TIMEN_ALL 8'hFF

// table sizes
`define SNT_CLIENTS 8
`define SNT_ID_BYTES 24
`define SNT_DBUF_BYTES 26
`define SNT_ACKPL_BYTES 4
`define SNT_DLEN_MAX 5'h1A
`define SNT_ACKLEN_MAX 3'h4

// timing
`define SNT_CLK_MHZ 100
`define SNT_LISTEN_MS 1000
`define SNT_LISTEN_CYC (`SNT_LISTEN_MS * 1000 * `SNT_CLK_MHZ)
`define SNT_ACK_WAIT_US 500
`define SNT_ACK_WAIT_CYC (`SNT_ACK_WAIT_US * `SNT_CLK_MHZ)

`endif

// >>> rtl/snt_pkg.sv
package snt_pkg;

    typedef enum logic [2:0] {
        SNT_BIDIR,
        SNT_ONEWAY,
        SNT_FAST,
        SNT_STREAM,
        SNT_BAD
    } snt_mode_type;

    typedef enum logic [3:0] {
        SNT_S_IDLE,
        SNT_S_WAKE,
        SNT_S_LISTEN,
        SNT_S_SLEEP,
        SNT_S_RXWIN,
        SNT_S_CONT,
        SNT_S_ACK,
        SNT_S_CWAIT
    } snt_state_type;

endpackage : snt_pkg

// >>> rtl/snt_buf.sv
`timescale 1ns/100ps
`default_nettype none
module snt_buf (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data
);
    logic [7:0] mem_q [2];
    logic [7:0] mem_d [2];
    logic wp_q, wp_d, rp_q, rp_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rp_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wp_q] = in_data;
            wp_d = !wp_q;
        end
        if (pop) begin
            rp_d = !rp_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : snt_buf
`default_nettype wire

// >>> rtl/snt_link.sv
// Overview of operation
// - the master keeps client ids in the id table at 0x08 to 0x1F and only those ids take part.
// - in timer packet mode the stored per-client timing wakes the receiver for each slot.
// - in bidirectional packet mode each packet's id is checked, data loaded, and an ack ends it.
// - every ack in the bidirectional modes may carry up to 4 payload bytes.
// - in one-way packet mode the slot opens from stored timing, ids compare, timers resync.
// - in fast packet mode the master receives permanently, checks the id and acks.
// - in streaming mode one known client sends up to 26 bytes while the master keeps receiving.
// - register 0x00 with power set selects the mode from its three mode bits.
// - in bidirectional and one-way packet mode, with all timers enabled in 0x01 the master starts the wakeup procedure.
// - after the wakeup the receiver stays on for one second for the clients' first data.
// - timing carried in a client's first data is stored in the secondary table 0x0C to 0x13.
// - a client waits a set time for the ack, flags it and ends the transmit command.
// - a known id with good crc raises the data-received interrupt and, in bidirectional and fast packet mode, gets an ack.
// - an unknown id with good crc raises the unknown-client interrupt, no ack, id shown.
`timescale 1ns/100ps
`default_nettype none
`include "snt_cfg.svh"
module snt_link #(
    parameter int unsigned LISTEN_CYC = `SNT_LISTEN_CYC,
    parameter int unsigned ACK_WAIT_CYC = `SNT_ACK_WAIT_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic wake_req,
    input wire logic wakeup_done,
    input wire logic slot_wake,
    output logic rx_on,
    input wire logic rx_hdr_valid,
    input wire logic [23:0] rx_id,
    input wire logic [7:0] rx_timing,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic rx_end,
    input wire logic rx_crc_ok,
    output logic timer_sync,
    output logic ack_req,
    output logic [2:0] ack_len,
    output logic [31:0] ack_payload,
    input wire logic ack_done,
    output logic data_rx_irq,
    output logic unknown_client_irq,
    input wire logic tx_done,
    input wire logic ack_seen,
    output logic ack_rx_irq,
    output logic rx_end_irq,
    output logic tx_cmd_end
);
    function automatic snt_pkg::snt_mode_type mode_dec(input logic [7:0] cfg);
        snt_pkg::snt_mode_type m;
        m = snt_pkg::SNT_BAD;
        unique case ({cfg[`SNT_CFG_TIMDIS], cfg[`SNT_CFG_UNIDIR], cfg[`SNT_CFG_STREAM]})
            3'b000: m = snt_pkg::SNT_BIDIR;
            3'b010: m = snt_pkg::SNT_ONEWAY;
            3'b100: m = snt_pkg::SNT_FAST;
            3'b111: m = snt_pkg::SNT_STREAM;
            default: m = snt_pkg::SNT_BAD;
        endcase
        return m;
    endfunction : mode_dec

    function automatic logic [3:0] id_find(input logic [191:0] tab, input logic [23:0] id);
        logic [3:0] r;
        r = 4'h0;
        for (int k = `SNT_CLIENTS - 1; k >= 0; k--) begin
            if (id != 24'h000000 && tab[k*24 +: 24] == id) begin
                r = {1'b1, 3'(k)};
            end
        end
        return r;
    endfunction : id_find

    logic [7:0] cfg_q, cfg_d, timen_q, timen_d, rdata_q, rdata_d, rd_v;
    logic [2:0] acklen_q, acklen_d;
    logic [7:0] ackpl_q [`SNT_ACKPL_BYTES];
    logic [7:0] ackpl_d [`SNT_ACKPL_BYTES];
    logic [7:0] id_tab_q [`SNT_ID_BYTES];
    logic [7:0] id_tab_d [`SNT_ID_BYTES];
    logic [7:0] tim_tab_q [`SNT_CLIENTS];
    logic [7:0] tim_tab_d [`SNT_CLIENTS];
    logic [7:0] dbuf_q [`SNT_DBUF_BYTES];
    logic [7:0] dbuf_d [`SNT_DBUF_BYTES];
    logic [23:0] id_new_q, id_new_d;
    logic [4:0] dlen_q, dlen_d;
    logic [191:0] id_flat;
    logic [3:0] found;
    snt_pkg::snt_mode_type mode;
    snt_pkg::snt_state_type st_q, st_d, ret_q, ret_d;
    logic [31:0] cnt_q, cnt_d;
    logic bank, ma, mode_ok, timed, hdr, end_fire, ack_go, store_tim;
    logic wake_q, wake_d, rxon_q, rxon_d, sync_q, sync_d, ackreq_q, ackreq_d;
    logic drx_q, drx_d, unk_q, unk_d, ackrx_q, ackrx_d, rxend_q, rxend_d;
    logic txend_q, txend_d, inpkt_q, inpkt_d, hit_q, hit_d, endp_q, endp_d;
    logic crc_q, crc_d;
    logic [2:0] idx_q, idx_d;
    logic [7:0] tim_q, tim_d;
    logic bi_valid, bi_ready, bo_valid, bo_ready;
    logic [7:0] bo_data;

    assign mode = mode_dec(cfg_q);
    assign mode_ok = cfg_q[`SNT_CFG_PWR] && (mode != snt_pkg::SNT_BAD);
    assign bank = cfg_q[`SNT_CFG_BANK];
    assign ma = cfg_q[`SNT_CFG_MASEN];
    assign timed = (mode == snt_pkg::SNT_BIDIR) || (mode == snt_pkg::SNT_ONEWAY);
    assign hdr = rx_hdr_valid && rxon_q && ma && !inpkt_q;
    assign end_fire = endp_q && !bo_valid;
    assign ack_go = end_fire && crc_q && hit_q
        && (mode == snt_pkg::SNT_BIDIR || mode == snt_pkg::SNT_FAST);
    assign store_tim = end_fire && crc_q && hit_q && timed;

    always_comb begin
        id_flat = 192'h0;
        for (int j = 0; j < `SNT_ID_BYTES; j++) begin
            id_flat[(j / 3) * 24 + (2 - j % 3) * 8 +: 8] = id_tab_q[j];
        end
    end
    assign found = id_find(id_flat, rx_id);

    assign bi_valid = rx_valid && inpkt_q;
    assign rx_ready = inpkt_q ? bi_ready : 1'b1;
    assign bo_ready = !reg_wr;

    snt_buf u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(bi_valid),
        .in_ready(bi_ready),
        .in_data(rx_data),
        .out_valid(bo_valid),
        .out_ready(bo_ready),
        .out_data(bo_data)
    );

    // register file and packet store
    always_comb begin
        cfg_d = cfg_q;
        timen_d = timen_q;
        acklen_d = acklen_q;
        ackpl_d = ackpl_q;
        id_tab_d = id_tab_q;
        tim_tab_d = tim_tab_q;
        dbuf_d = dbuf_q;
        id_new_d = id_new_q;
        dlen_d = dlen_q;
        rd_v = 8'h00;
        if (reg_wr) begin
            if (reg_addr == `SNT_ADDR_CFG) cfg_d = reg_wdata;
            if (reg_addr == `SNT_ADDR_TIMEN) timen_d = reg_wdata;
            if (reg_addr == `SNT_ADDR_ACKLEN) begin
                acklen_d = (reg_wdata[2:0] > `SNT_ACKLEN_MAX) ? `SNT_ACKLEN_MAX : reg_wdata[2:0];
            end
            for (int i = 0; i < `SNT_ACKPL_BYTES; i++) begin
                if (reg_addr == 7'(`SNT_ADDR_ACKPL + i)) ackpl_d[i] = reg_wdata;
            end
            for (int i = 0; i < `SNT_ID_BYTES; i++) begin
                if (!bank && reg_addr == 7'(`SNT_ADDR_IDTAB + i)) id_tab_d[i] = reg_wdata;
            end
            for (int i = 0; i < `SNT_CLIENTS; i++) begin
                if (bank && reg_addr == 7'(`SNT_ADDR_TIMTAB + i)) tim_tab_d[i] = reg_wdata;
            end
        end
        if (hdr) begin
            id_new_d = rx_id;
            dlen_d = 5'h00;
        end
        if (bo_valid && bo_ready && hit_q && dlen_q < `SNT_DLEN_MAX) begin
            dbuf_d[dlen_q] = bo_data;
            dlen_d = dlen_q + 5'h01;
        end
        if (store_tim) tim_tab_d[idx_q] = tim_q;
        if (reg_addr == `SNT_ADDR_CFG) rd_v = cfg_q;
        if (reg_addr == `SNT_ADDR_TIMEN) rd_v = timen_q;
        if (reg_addr == `SNT_ADDR_ACKLEN) rd_v = {5'h00, acklen_q};
        if (reg_addr == `SNT_ADDR_STATUS) rd_v = {rxon_q, 3'h0, st_q};
        if (reg_addr == `SNT_ADDR_DLEN) rd_v = {3'h0, dlen_q};
        for (int i = 0; i < `SNT_ACKPL_BYTES; i++) begin
            if (reg_addr == 7'(`SNT_ADDR_ACKPL + i)) rd_v = ackpl_q[i];
        end
        for (int i = 0; i < `SNT_ID_BYTES; i++) begin
            if (!bank && reg_addr == 7'(`SNT_ADDR_IDTAB + i)) rd_v = id_tab_q[i];
        end
        for (int i = 0; i < `SNT_CLIENTS; i++) begin
            if (bank && reg_addr == 7'(`SNT_ADDR_TIMTAB + i)) rd_v = tim_tab_q[i];
        end
        for (int i = 0; i < 3; i++) begin
            if (reg_addr == 7'(`SNT_ADDR_IDNEW + i)) rd_v = id_new_q[(2 - i) * 8 +: 8];
        end
        for (int i = 0; i < `SNT_DBUF_BYTES; i++) begin
            if (reg_addr == 7'(`SNT_ADDR_DBUF + i)) rd_v = dbuf_q[i];
        end
        rdata_d = reg_rd ? rd_v : rdata_q;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_q <= `SNT_CFG_RST;
            timen_q <= `SNT_TIMEN_RST;
            acklen_q <= 3'h0;
            rdata_q <= 8'h00;
            id_new_q <= 24'h000000;
            dlen_q <= 5'h00;
            for (int i = 0; i < `SNT_ACKPL_BYTES; i++) ackpl_q[i] <= 8'h00;
            for (int i = 0; i < `SNT_ID_BYTES; i++) id_tab_q[i] <= 8'h00;
            for (int i = 0; i < `SNT_CLIENTS; i++) tim_tab_q[i] <= 8'h00;
            for (int i = 0; i < `SNT_DBUF_BYTES; i++) dbuf_q[i] <= 8'h00;
        end else begin
            cfg_q <= cfg_d;
            timen_q <= timen_d;
            acklen_q <= acklen_d;
            rdata_q <= rdata_d;
            id_new_q <= id_new_d;
            dlen_q <= dlen_d;
            ackpl_q <= ackpl_d;
            id_tab_q <= id_tab_d;
            tim_tab_q <= tim_tab_d;
            dbuf_q <= dbuf_d;
        end
    end

    // sequencer and packet tracking
    always_comb begin
        st_d = st_q;
        ret_d = ret_q;
        cnt_d = cnt_q;
        wake_d = 1'b0;
        ackreq_d = 1'b0;
        ackrx_d = 1'b0;
        rxend_d = 1'b0;
        txend_d = 1'b0;
        unique case (st_q)
            snt_pkg::SNT_S_IDLE: begin
                if (ma && mode_ok) begin
                    if (timed && timen_q == `SNT_TIMEN_ALL) begin
                        wake_d = 1'b1;
                        st_d = snt_pkg::SNT_S_WAKE;
                    end else if (!timed) begin
                        st_d = snt_pkg::SNT_S_CONT;
                    end
                end else if (!ma && tx_done) begin
                    cnt_d = 32'h0;
                    st_d = snt_pkg::SNT_S_CWAIT;
                end
            end
            snt_pkg::SNT_S_WAKE: begin
                if (wakeup_done) begin
                    cnt_d = 32'h0;
                    st_d = snt_pkg::SNT_S_LISTEN;
                end
            end
            snt_pkg::SNT_S_LISTEN: begin
                cnt_d = cnt_q + 32'h1;
                if (ack_go) begin
                    ackreq_d = 1'b1;
                    ret_d = snt_pkg::SNT_S_LISTEN;
                    st_d = snt_pkg::SNT_S_ACK;
                end else if (cnt_q >= LISTEN_CYC - 1) begin
                    st_d = snt_pkg::SNT_S_SLEEP;
                end
            end
            snt_pkg::SNT_S_SLEEP: begin
                if (slot_wake) st_d = snt_pkg::SNT_S_RXWIN;
            end
            snt_pkg::SNT_S_RXWIN: begin
                if (ack_go) begin
                    ackreq_d = 1'b1;
                    ret_d = snt_pkg::SNT_S_SLEEP;
                    st_d = snt_pkg::SNT_S_ACK;
                end else if (end_fire) begin
                    st_d = snt_pkg::SNT_S_SLEEP;
                end
            end
            snt_pkg::SNT_S_CONT: begin
                if (ack_go) begin
                    ackreq_d = 1'b1;
                    ret_d = snt_pkg::SNT_S_CONT;
                    st_d = snt_pkg::SNT_S_ACK;
                end
            end
            snt_pkg::SNT_S_ACK: begin
                if (ret_q == snt_pkg::SNT_S_LISTEN && cnt_q < LISTEN_CYC - 1) begin
                    cnt_d = cnt_q + 32'h1;
                end
                if (ack_done) begin
                    st_d = ret_q;
                    if (ret_q == snt_pkg::SNT_S_LISTEN && cnt_q >= LISTEN_CYC - 1) begin
                        st_d = snt_pkg::SNT_S_SLEEP;
                    end
                end
            end
            snt_pkg::SNT_S_CWAIT: begin
                cnt_d = cnt_q + 32'h1;
                if (ack_seen) begin
                    ackrx_d = 1'b1;
                    txend_d = 1'b1;
                    st_d = snt_pkg::SNT_S_IDLE;
                end else if (cnt_q >= ACK_WAIT_CYC - 1) begin
                    rxend_d = 1'b1;
                    st_d = snt_pkg::SNT_S_IDLE;
                end
            end
        endcase
        // leave when the master is disabled, power is off or the mode is bad
        if (st_q != snt_pkg::SNT_S_CWAIT && st_q != snt_pkg::SNT_S_IDLE && !(ma && mode_ok)) begin
            st_d = snt_pkg::SNT_S_IDLE;
            ackreq_d = 1'b0;
        end
        rxon_d = (st_d == snt_pkg::SNT_S_LISTEN) || (st_d == snt_pkg::SNT_S_RXWIN)
            || (st_d == snt_pkg::SNT_S_CONT) || (st_d == snt_pkg::SNT_S_CWAIT);
        inpkt_d = inpkt_q;
        hit_d = hit_q;
        idx_d = idx_q;
        tim_d = tim_q;
        endp_d = endp_q;
        crc_d = crc_q;
        if (hdr) begin
            inpkt_d = 1'b1;
            hit_d = found[3];
            idx_d = found[2:0];
            tim_d = rx_timing;
        end
        if (inpkt_q && rx_end && !endp_q) begin
            endp_d = 1'b1;
            crc_d = rx_crc_ok;
        end
        if (end_fire) begin
            endp_d = 1'b0;
            inpkt_d = 1'b0;
        end
        sync_d = hdr && found[3] && timed;
        drx_d = end_fire && crc_q && hit_q;
        unk_d = end_fire && crc_q && !hit_q;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_q <= snt_pkg::SNT_S_IDLE;
            ret_q <= snt_pkg::SNT_S_IDLE;
            cnt_q <= 32'h0;
            {wake_q, rxon_q, sync_q, ackreq_q, drx_q, unk_q} <= 6'h00;
            {ackrx_q, rxend_q, txend_q, inpkt_q, hit_q, endp_q, crc_q} <= 7'h00;
            idx_q <= 3'h0;
            tim_q <= 8'h00;
        end else begin
            st_q <= st_d;
            ret_q <= ret_d;
            cnt_q <= cnt_d;
            {wake_q, rxon_q, sync_q, ackreq_q, drx_q, unk_q} <=
                {wake_d, rxon_d, sync_d, ackreq_d, drx_d, unk_d};
            {ackrx_q, rxend_q, txend_q, inpkt_q, hit_q, endp_q, crc_q} <=
                {ackrx_d, rxend_d, txend_d, inpkt_d, hit_d, endp_d, crc_d};
            idx_q <= idx_d;
            tim_q <= tim_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign wake_req = wake_q;
    assign rx_on = rxon_q;
    assign timer_sync = sync_q;
    assign ack_req = ackreq_q;
    assign ack_len = acklen_q;
    assign ack_payload = {ackpl_q[0], ackpl_q[1], ackpl_q[2], ackpl_q[3]};
    assign data_rx_irq = drx_q;
    assign unknown_client_irq = unk_q;
    assign ack_rx_irq = ackrx_q;
    assign rx_end_irq = rxend_q;
    assign tx_cmd_end = txend_q;

    property p_unknown_no_ack;
        @(posedge clk) disable iff (sys_rst) unknown_client_irq |-> !ack_req ##1 !ack_req;
    endproperty
    a_unknown_no_ack: assert property (p_unknown_no_ack) else $error("ack after unknown id");

    property p_ack_with_data;
        @(posedge clk) disable iff (sys_rst) ack_req |-> data_rx_irq && ack_len <= 3'h4;
    endproperty
    a_ack_with_data: assert property (p_ack_with_data) else $error("ack without data event");

    property p_wake_start;
        @(posedge clk) disable iff (sys_rst)
            wake_req |-> st_q == snt_pkg::SNT_S_WAKE && $past(timen_q) == `SNT_TIMEN_ALL;
    endproperty
    a_wake_start: assert property (p_wake_start) else $error("wakeup without all timers");

    property p_listen_bound;
        @(posedge clk) disable iff (sys_rst)
            st_q == snt_pkg::SNT_S_LISTEN |-> rx_on && cnt_q < LISTEN_CYC;
    endproperty
    a_listen_bound: assert property (p_listen_bound) else $error("listen overran");

    property p_bad_mode;
        @(posedge clk) disable iff (sys_rst)
            ma && !mode_ok && st_q != snt_pkg::SNT_S_CWAIT |=> st_q == snt_pkg::SNT_S_IDLE;
    endproperty
    a_bad_mode: assert property (p_bad_mode) else $error("sequence in undefined mode");

    property p_stream_rx;
        @(posedge clk) disable iff (sys_rst)
            st_q == snt_pkg::SNT_S_CONT && mode == snt_pkg::SNT_STREAM |-> rx_on && !ack_req;
    endproperty
    a_stream_rx: assert property (p_stream_rx) else $error("streaming not receiving");

    property p_dlen_max;
        @(posedge clk) disable iff (sys_rst) dlen_q <= `SNT_DLEN_MAX;
    endproperty
    a_dlen_max: assert property (p_dlen_max) else $error("data length above 26");

    property p_tim_store;
        @(posedge clk) disable iff (sys_rst) store_tim |=> tim_tab_q[$past(idx_q)] == $past(tim_q);
    endproperty
    a_tim_store: assert property (p_tim_store) else $error("timing not stored");

    property p_sync;
        @(posedge clk) disable iff (sys_rst) hdr && found[3] && timed |=> timer_sync;
    endproperty
    a_sync: assert property (p_sync) else $error("no resync on match");

    property p_client_ack;
        @(posedge clk) disable iff (sys_rst)
            st_q == snt_pkg::SNT_S_CWAIT && ack_seen |=> ack_rx_irq && tx_cmd_end ##1 !ack_rx_irq;
    endproperty
    a_client_ack: assert property (p_client_ack) else $error("ack not flagged");

    property p_irq_excl;
        @(posedge clk) disable iff (sys_rst) !(data_rx_irq && unknown_client_irq);
    endproperty
    a_irq_excl: assert property (p_irq_excl) else $error("both receive events");
endmodule : snt_link
`default_nettype wire

// >>> verif/snt_peer.sv
`timescale 1ns/100ps
`default_nettype none
module snt_peer (
    input wire logic clk,
    input wire logic wake_req,
    input wire logic ack_req,
    input wire logic rx_ready,
    output logic wakeup_done = '0,
    output logic ack_done = '0,
    output logic rx_hdr_valid = '0,
    output logic [23:0] rx_id = '0,
    output logic [7:0] rx_timing = 8'h5A,
    output logic rx_valid = '0,
    output logic [7:0] rx_data = '0,
    output logic rx_end = '0,
    output logic rx_crc_ok = '0
);
    logic [7:0] pl [32];
    always @(posedge clk) if (wake_req) begin
        @(negedge clk) wakeup_done = 1;
        @(negedge clk) wakeup_done = 0;
    end
    always @(posedge clk) if (ack_req) begin
        repeat (2) @(negedge clk);
        ack_done = 1;
        @(negedge clk) ack_done = 0;
    end
    task automatic send(input logic [23:0] id, input int n, input logic crc, input int gap);
        @(negedge clk) rx_hdr_valid = 1;
        rx_id = id;
        @(negedge clk) rx_hdr_valid = 0;
        rx_id = ~id;
        rx_valid = 1;
        for (int k = 0; k < n; k++) begin
            rx_data = pl[k];
            #1;
            while (!rx_ready) @(negedge clk) #1;
            @(negedge clk);
            if (gap > 0 && k < n - 1) begin
                rx_valid = 0;
                rx_data = ~pl[k];
                repeat (gap) @(negedge clk);
                rx_valid = 1;
            end
        end
        rx_valid = 0;
        rx_data = ~rx_data;
        rx_end = 1;
        rx_crc_ok = crc;
        @(negedge clk) rx_end = 0;
        rx_crc_ok = 0;
    endtask : send
endmodule : snt_peer
`default_nettype wire

// >>> verif/star_network_transmission_modes_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("unexpected at %0t got %h exp %h", $time, a, e); end end
module star_network_transmission_modes_bench;
    logic clk = '0, sys_rst = '1, reg_wr = '0, reg_rd = '0, slot_wake = '0, tx_done = '0;
    logic ack_seen = '0, rd_d, wake_req, wakeup_done, rx_on, rx_hdr_valid, rx_valid, rx_ready;
    logic rx_end, rx_crc_ok, timer_sync, ack_req, ack_done, data_rx_irq, unknown_client_irq;
    logic ack_rx_irq, rx_end_irq, tx_cmd_end;
    logic [6:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0, reg_rdata, rx_timing, rx_data;
    logic [23:0] rx_id;
    logic [2:0] ack_len;
    logic [31:0] ack_payload, seed = 32'h0000003D;
    logic [7:0] q [$];
    int fail_count = 0, n_checks = 0, cyc = 0;
    snt_link #(.LISTEN_CYC(200), .ACK_WAIT_CYC(50)) i_snt_link (.*);
    snt_peer i_snt_peer (.*);
    initial forever #5 clk = ~clk;
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    task automatic summarize();
        if (fail_count == 0 && n_checks > 0 && q.size() == 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input logic [7:0] v);
        logic [7:0] e;
        e = q.size() ? q.pop_front() : 8'hXX;
        `CHK(v, e)
    endtask : chk
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d) chk(reg_rdata);
        if (timer_sync) chk(8'h55);
        if (data_rx_irq) chk({7'h50, ack_req});
        if (unknown_client_irq) chk({7'h70, ack_req});
        if (wake_req) chk(8'hB0);
        if (ack_rx_irq) chk({7'h60, tx_cmd_end});
        if (rx_end_irq) chk(8'hD0);
        if (ack_req) `CHK(ack_payload, 32'hC0C1C2C3)
        if (ack_req) `CHK(ack_len, 3'h4)
        if (++cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic wq();
        for (int i = 0; i < 3000 && q.size() > 0; i++) @(negedge clk);
        repeat (8) @(negedge clk);
    endtask : wq
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clk) reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk) reg_wr = 0;
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        q.push_back(e);
        @(negedge clk) reg_rd = 1;
        reg_addr = a;
        @(negedge clk) reg_rd = 0;
        wq();
    endtask : rd
    task automatic rxw();
        for (int i = 0; i < 500 && rx_on !== 1'b1; i++) @(negedge clk);
    endtask : rxw
    task automatic pkt(input logic [23:0] id, input int n, input logic crc, input logic s,
                       input logic [7:0] c);
        for (int k = 0; k < n; k++) i_snt_peer.pl[k] = rnd();
        if (s) q.push_back(8'h55);
        if (c != 8'h00) q.push_back(c);
        i_snt_peer.send(id, n, crc, rnd() % 3);
        wq();
    endtask : pkt
    task automatic cli(input logic ack);
        q.push_back(ack ? 8'hC1 : 8'hD0);
        @(negedge clk) tx_done = 1;
        @(negedge clk) tx_done = 0;
        repeat (4) @(negedge clk);
        ack_seen = ack;
        @(negedge clk) ack_seen = 0;
        wq();
    endtask : cli
    initial begin
        repeat (2) @(posedge clk);
        @(negedge clk) sys_rst = 0;
        wr(7'h01, 8'hFF);
        wr(7'h00, 8'h8A);
        rd(7'h00, 8'h8A);
        rd(7'h03, 8'h00);
        rd(7'h7F, 8'h00);
        wr(7'h02, 8'h07);
        rd(7'h02, 8'h04);
        for (int k = 0; k < 4; k++) wr(7'h04 + 7'(k), 8'hC0 + 8'(k));
        for (int k = 0; k < 3; k++) wr(7'h08 + 7'(k), 8'h12 + 8'(k * 34));
        wr(7'h00, 8'hA2);
        rxw();
        pkt(24'h123456, 26, 1, 0, 8'hA1);
        rd(7'h37, 8'h1A);
        rd(7'h51, i_snt_peer.pl[25]);
        pkt(24'hABCDEF, 2, 1, 0, 8'hE0);
        rd(7'h34, 8'hAB);
        pkt(24'h123456, 3, 0, 0, 8'h00);
        pkt(24'h123456, 1, 1, 0, 8'hA1);
        rd(7'h38, i_snt_peer.pl[0]);
        wr(7'h00, 8'hBA);
        rxw();
        pkt(24'h123456, 4, 1, 0, 8'hA0);
        wr(7'h00, 8'h80);
        q.push_back(8'hB0);
        wr(7'h00, 8'h92);
        rxw();
        pkt(24'h123456, 1, 1, 1, 8'hA0);
        wr(7'h00, 8'h80);
        q.push_back(8'hB0);
        wr(7'h00, 8'h82);
        rxw();
        pkt(24'h123456, 2, 1, 1, 8'hA1);
        repeat (250) @(negedge clk);
        `CHK(rx_on, 1'b0)
        @(negedge clk) slot_wake = 1;
        @(negedge clk) slot_wake = 0;
        rxw();
        pkt(24'h123456, 2, 1, 1, 8'hA1);
        wr(7'h00, 8'h83);
        rd(7'h0C, 8'h5A);
        wr(7'h00, 8'h02);
        cli(1);
        cli(0);
        summarize();
    end
endmodule : star_network_transmission_modes_bench
`default_nettype wire
